// ### hw/mac_stats_pkg.sv
package mac_stats_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 32;
    localparam int          NUM_CNT             = 9;
    localparam int          CNT_W               = 16;

    // Counter indices, also their word index from offset zero
    localparam int          CNT_NO_BUF          = 0;
    localparam int          CNT_OVERRUN         = 1;
    localparam int          CNT_SYMBOL          = 2;
    localparam int          CNT_OVER_CLEAN      = 3;
    localparam int          CNT_OVER_BAD        = 4;
    localparam int          CNT_SHORT_CLEAN     = 5;
    localparam int          CNT_HEARTBEAT       = 6;
    localparam int          CNT_LEN_MISMATCH    = 7;
    localparam int          CNT_TX_UNDERRUN     = 8;

    localparam logic [7:0]  OFF_CNT_BASE        = 8'h00;
    localparam logic [7:0]  OFF_NET_CFG         = 8'h24;
    localparam logic [7:0]  OFF_IRQ_STATUS      = 8'h28;
    localparam logic [7:0]  OFF_IRQ_MASK        = 8'h2C;
    localparam logic [1:0]  WORD_LSB_ZERO       = 2'h0;

    // Network configuration fields
    localparam int          CFG_SPEED100_BIT    = 0;
    localparam int          CFG_FULL_DUPLEX_BIT = 1;
    localparam int          CFG_BIG_FRAMES_BIT  = 8;
    localparam int          CFG_LEN_CHECK_BIT   = 16;
    localparam logic [31:0] NET_CFG_RESET       = 32'h0000_0000;
    localparam logic [31:0] NET_CFG_MASK        = 32'h0001_0103;
    localparam logic [15:0] CNT_RESET           = 16'h0000;
    localparam logic [15:0] CNT_MASK_WIDE       = 16'hFFFF;
    localparam logic [15:0] CNT_MASK_NARROW     = 16'h00FF;
    localparam logic [8:0]  IRQ_RESET           = 9'h000;

    // ------------------------------------------------------------
    // Frame lengths in bytes
    // ------------------------------------------------------------
    localparam logic [15:0] MIN_FRAME_LEN       = 16'h0040;
    localparam logic [15:0] MAX_FRAME_LEN       = 16'h05EE;
    localparam logic [15:0] MAX_BIG_FRAME_LEN   = 16'h0600;
    localparam logic [15:0] TYPE_ID_MIN         = 16'h0600;
    localparam logic [15:0] FRAME_OVERHEAD      = 16'h0012;

    // ------------------------------------------------------------
    // Heartbeat window timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS       = 50;
    localparam int          SQE_WINDOW_BITS     = 96;
    localparam int          BIT_NS_10M          = 100;
    localparam int          BIT_NS_100M         = 10;
    localparam int          SQE_WIN_W           = 8;
    localparam logic [7:0]  SQE_CYC_10M  = 8'((SQE_WINDOW_BITS * BIT_NS_10M) / CLK_PERIOD_NS);
    localparam logic [7:0]  SQE_CYC_100M = 8'((SQE_WINDOW_BITS * BIT_NS_100M) / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [15:0] len;
        logic [15:0] lenField;
        logic        addrMatch;
        logic        noBuffer;
        logic        dmaOverrun;
        logic        crcErr;
        logic        alignErr;
        logic        symErr;
    } rx_frame_t;

    typedef struct packed {
        logic noBuf;
        logic overrun;
        logic symbol;
        logic overClean;
        logic overBad;
        logic shortClean;
        logic lenMismatch;
        logic fcsErr;
        logic alignErr;
    } rx_events_t;

endpackage : mac_stats_pkg

// ### hw/rx_frame_classifier.sv
`timescale 1ns/100ps
module rx_frame_classifier
    import mac_stats_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire rx_frame_t  frame,
    input  wire logic       bigFrames,
    input  wire logic       lenCheck,
    output rx_events_t      events
);

    logic        bad;
    logic        oversize;
    logic        validLen;
    logic [15:0] maxLen;
    logic [16:0] fieldLen;

    // Error and length classes of the finished frame
    assign maxLen   = bigFrames ? MAX_BIG_FRAME_LEN : MAX_FRAME_LEN;
    assign bad      = frame.crcErr | frame.alignErr | frame.symErr;
    assign oversize = frame.len > maxLen;
    assign validLen = (frame.len >= MIN_FRAME_LEN) && !oversize;
    // Field plus overhead is added, so runt frames cannot wrap past the field
    assign fieldLen = {1'b0, frame.lenField} + {1'b0, FRAME_OVERHEAD};

    // One registered pulse per class, one cycle after the frame report
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            events <= '0;
        end else begin
            events.noBuf       <= frame.valid & frame.addrMatch & frame.noBuffer;
            events.overrun     <= frame.valid & frame.addrMatch & frame.dmaOverrun;
            events.symbol      <= frame.valid & frame.symErr;
            events.overClean   <= frame.valid & oversize & !bad;
            events.overBad     <= frame.valid & oversize & bad;
            events.shortClean  <= frame.valid & (frame.len < MIN_FRAME_LEN) & !bad;
            events.fcsErr      <= frame.valid & validLen & !frame.alignErr
                                  & (frame.crcErr | frame.symErr);
            events.alignErr    <= frame.valid & validLen & frame.alignErr
                                  & (frame.crcErr | frame.symErr);
            events.lenMismatch <= frame.valid & lenCheck
                                  & (frame.lenField < TYPE_ID_MIN) & !oversize
                                  & ({1'b0, frame.len} < fieldLen);
        end
    end

endmodule : rx_frame_classifier

// ### hw/heartbeat_checker.sv
`timescale 1ns/100ps
module heartbeat_checker
    import mac_stats_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       txEn,
    input  wire logic       colSync,
    input  wire logic       txUnderrun,
    input  wire logic       halfDuplex,
    input  wire logic       speed100,
    output logic            failPulse
);

    typedef enum logic [1:0] {HB_IDLE, HB_TX, HB_WAIT} hb_state_t;

    hb_state_t              state_r;
    logic [SQE_WIN_W-1:0]   winCnt_r;
    logic                   underrunSeen_r;
    logic                   txEnDly_r;

    // Transmit enable history for the rising edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) txEnDly_r <= 1'b0;
        else         txEnDly_r <= txEn;
    end

    // An underrun frame must not also count a heartbeat failure
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            underrunSeen_r <= 1'b0;
        end else if (txEn && !txEnDly_r) begin
            underrunSeen_r <= txUnderrun;
        end else if (txUnderrun) begin
            underrunSeen_r <= 1'b1;
        end
    end

    // Window of 96 bit times after transmit enable drops
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r   <= HB_IDLE;
            winCnt_r  <= '0;
            failPulse <= 1'b0;
        end else begin
            failPulse <= 1'b0;
            case (state_r)
                HB_IDLE: begin
                    if (txEn) state_r <= HB_TX;
                end
                HB_TX: begin
                    if (!txEn) begin
                        // Full duplex has no heartbeat, so nothing is watched
                        state_r  <= halfDuplex ? HB_WAIT : HB_IDLE;
                        winCnt_r <= speed100 ? SQE_CYC_100M : SQE_CYC_10M;
                    end
                end
                HB_WAIT: begin
                    if (colSync) begin
                        state_r <= txEn ? HB_TX : HB_IDLE;
                    end else if (winCnt_r == SQE_WIN_W'(1)) begin
                        failPulse <= !underrunSeen_r;
                        state_r   <= txEn ? HB_TX : HB_IDLE;
                    end else begin
                        winCnt_r <= winCnt_r - SQE_WIN_W'(1);
                    end
                end
                default: state_r <= HB_IDLE;
            endcase
        end
    end

endmodule : heartbeat_checker

// ### hw/mac_rx_error_statistics.sv
// Function
// - 16-bit count of address-matched frames dropped for lack of receive buffer.
// - 8-bit count of address-matched frames dropped by receive DMA overrun.
// - 8-bit count of frames received with the PHY receive error asserted.
// - Symbol error counts as CRC/alignment in valid length, jabber when longer.
// - Config bit 8 raises the maximum valid length from 1518 to 1536.
// - 8-bit count of oversize frames without CRC, alignment or symbol error.
// - 8-bit count of oversize frames with CRC, alignment or symbol error.
// - 8-bit count of clean frames shorter than 64 bytes.
// - Half duplex: count frames lacking collision within 96 bit times of end.
// - 8-bit count of frames shorter than their length field says.
// - Length field checked only while config bit 16 is set.
// - No mismatch counted for type values from 0x0600 or oversize frames.
// - A transmit underrun frame changes no other counter.
`timescale 1ns/100ps
module mac_rx_error_statistics
    import mac_stats_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic [ADDR_W-1:0]  regAddr,
    input  wire logic [DATA_W-1:0]  regWrData,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [DATA_W-1:0]  regRdData,
    input  wire rx_frame_t          rxFrame,
    input  wire logic               txEn,
    input  wire logic               txUnderrun,
    input  wire logic               phyCol,
    output logic                    fcsErrInc,
    output logic                    alignErrInc,
    output logic                    irq
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Only the buffer-shortage counter is wide; the rest are byte counters
    function automatic logic [CNT_W-1:0] cntMask(input int idx);
        cntMask = (idx == CNT_NO_BUF) ? CNT_MASK_WIDE : CNT_MASK_NARROW;
    endfunction : cntMask

    function automatic logic [ADDR_W-1:0] cntOffset(input int idx);
        cntOffset = OFF_CNT_BASE + ADDR_W'(idx * 4);
    endfunction : cntOffset

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CNT_W-1:0]   cnt_r [NUM_CNT];
    logic [31:0]        netCfg_r;
    logic [NUM_CNT-1:0] irqStatus_r;
    logic [NUM_CNT-1:0] irqMask_r;
    logic [NUM_CNT-1:0] incVec;
    logic [DATA_W-1:0]  rdMux;
    logic               colMeta_r;
    logic               colSync_r;
    logic               heartbeatFail;
    rx_events_t         rxEvents;

    // ------------------------------------------------------------
    // Collision pin synchroniser
    // ------------------------------------------------------------
    // Collision comes straight from the PHY, so it is asynchronous here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            colMeta_r <= 1'b0;
            colSync_r <= 1'b0;
        end else begin
            colMeta_r <= phyCol;
            colSync_r <= colMeta_r;
        end
    end

    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    rx_frame_classifier u_classifier (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .frame     (rxFrame),
        .bigFrames (netCfg_r[CFG_BIG_FRAMES_BIT]),
        .lenCheck  (netCfg_r[CFG_LEN_CHECK_BIT]),
        .events    (rxEvents)
    );

    heartbeat_checker u_heartbeat (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .txEn       (txEn),
        .colSync    (colSync_r),
        .txUnderrun (txUnderrun),
        .halfDuplex (!netCfg_r[CFG_FULL_DUPLEX_BIT]),
        .speed100   (netCfg_r[CFG_SPEED100_BIT]),
        .failPulse  (heartbeatFail)
    );

    // Counting events, one pulse each
    always_comb begin
        incVec                   = '0;
        incVec[CNT_NO_BUF]       = rxEvents.noBuf;
        incVec[CNT_OVERRUN]      = rxEvents.overrun;
        incVec[CNT_SYMBOL]       = rxEvents.symbol;
        incVec[CNT_OVER_CLEAN]   = rxEvents.overClean;
        incVec[CNT_OVER_BAD]     = rxEvents.overBad;
        incVec[CNT_SHORT_CLEAN]  = rxEvents.shortClean;
        incVec[CNT_HEARTBEAT]    = heartbeatFail;
        incVec[CNT_LEN_MISMATCH] = rxEvents.lenMismatch;
        incVec[CNT_TX_UNDERRUN]  = txUnderrun;
    end

    // Error pulses handed on to the CRC and alignment counters elsewhere
    assign fcsErrInc   = rxEvents.fcsErr;
    assign alignErrInc = rxEvents.alignErr;

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    // A write in the same cycle as an event wins; the event is then lost
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_CNT; i++) cnt_r[i] <= CNT_RESET;
        end else begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (regWr && regAddr == cntOffset(i)) begin
                    cnt_r[i] <= regWrData[CNT_W-1:0] & cntMask(i);
                end else if (incVec[i]) begin
                    cnt_r[i] <= (cnt_r[i] + CNT_W'(1)) & cntMask(i);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration and interrupt registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            netCfg_r <= NET_CFG_RESET;
        end else if (regWr && regAddr == OFF_NET_CFG) begin
            netCfg_r <= regWrData & NET_CFG_MASK;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqMask_r <= IRQ_RESET;
        end else if (regWr && regAddr == OFF_IRQ_MASK) begin
            irqMask_r <= regWrData[NUM_CNT-1:0];
        end
    end

    // Write one to clear; a new event in the clearing cycle keeps its bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStatus_r <= IRQ_RESET;
        end else if (regWr && regAddr == OFF_IRQ_STATUS) begin
            irqStatus_r <= (irqStatus_r & ~regWrData[NUM_CNT-1:0]) | incVec;
        end else begin
            irqStatus_r <= irqStatus_r | incVec;
        end
    end

    assign irq = |(irqStatus_r & irqMask_r);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Unmapped addresses read zero; writes to them are dropped
    always_comb begin
        rdMux = '0;
        for (int i = 0; i < NUM_CNT; i++) begin
            if (regAddr == cntOffset(i)) rdMux = {16'h0000, cnt_r[i]};
        end
        if (regAddr == OFF_NET_CFG)    rdMux = netCfg_r;
        if (regAddr == OFF_IRQ_STATUS) rdMux = {23'h00_0000, irqStatus_r};
        if (regAddr == OFF_IRQ_MASK)   rdMux = {23'h00_0000, irqMask_r};
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)    regRdData <= '0;
        else if (regRd) regRdData <= rdMux;
        else            regRdData <= '0;
    end

endmodule : mac_rx_error_statistics

// ### verif/mac_stats_checker_sva.sv
`timescale 1ns/100ps
module mac_stats_checker
    import mac_stats_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    input  wire logic [DATA_W-1:0] regRdData,
    input  wire rx_frame_t         rxFrame,
    input  wire logic              txEn,
    input  wire logic              txUnderrun,
    input  wire logic              phyCol,
    input  wire logic              fcsErrInc,
    input  wire logic              alignErrInc,
    input  wire logic              irq
);
    // ----------------------------------------
    // Length window helper
    // ----------------------------------------
    logic bigCfg_r;
    logic inRange;

    // Shadow of the 1536 enable, since netCfg is not visible at the ports
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bigCfg_r <= 1'b0;
        end else if (regWr && regAddr == OFF_NET_CFG) begin
            bigCfg_r <= regWrData[CFG_BIG_FRAMES_BIT];
        end
    end

    // Valid length band for CRC and alignment pulses
    assign inRange = rxFrame.valid && rxFrame.len >= MIN_FRAME_LEN
                     && rxFrame.len <= (bigCfg_r ? MAX_BIG_FRAME_LEN : MAX_FRAME_LEN);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_rd_data_idle: assert property (!regRd |=> regRdData == '0)
        else $error("read data not zero outside read answer");
    a_rd_unmapped: assert property (regRd && regAddr == 8'h40 |=> regRdData == '0)
        else $error("unmapped read not zero");
    a_fcs_in_band: assert property (inRange && rxFrame.crcErr && !rxFrame.alignErr
        |=> fcsErrInc && !alignErrInc)
        else $error("crc frame in band gave no crc pulse");
    a_align_in_band: assert property (inRange && rxFrame.alignErr
        && (rxFrame.crcErr || rxFrame.symErr) |=> alignErrInc && !fcsErrInc)
        else $error("alignment pulse wrong");
    a_symbol_as_fcs: assert property (inRange && rxFrame.symErr && !rxFrame.alignErr
        |=> fcsErrInc)
        else $error("symbol error not counted as crc");
    a_out_band_quiet: assert property (rxFrame.valid && !inRange
        |=> !fcsErrInc && !alignErrInc)
        else $error("crc pulse outside length band");
    a_clean_quiet: assert property (inRange && !rxFrame.crcErr && !rxFrame.symErr
        |=> !fcsErrInc && !alignErrInc)
        else $error("clean frame gave error pulse");
    a_idle_quiet: assert property (!rxFrame.valid |=> !fcsErrInc && !alignErrInc)
        else $error("error pulse without frame");
    a_mask_irq: assert property (regWr && regAddr == OFF_IRQ_MASK
        && regWrData[8:0] == 9'h000 |=> !irq)
        else $error("irq high with mask cleared");

    c_crc_band: cover property (inRange && rxFrame.crcErr);
    c_oversize: cover property (rxFrame.valid && !inRange);
    c_mask_wr: cover property (regWr && regAddr == OFF_IRQ_MASK);
endmodule : mac_stats_checker

bind mac_rx_error_statistics mac_stats_checker mac_stats_checker_i (
    .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxFrame(rxFrame),
    .txEn(txEn), .txUnderrun(txUnderrun), .phyCol(phyCol),
    .fcsErrInc(fcsErrInc), .alignErrInc(alignErrInc), .irq(irq));

// ### verif/phy_col_model.sv
`timescale 1ns/100ps
module phy_col_model (
    input  wire logic       clk,
    input  wire logic       txEn,
    input  wire logic       colOn,
    input  wire logic [7:0] colDelay,
    output logic            phyCol
);
    // ----------------------------------------
    // Heartbeat answer
    // ----------------------------------------
    // Collision test pulse after transmit end; a late delay misses the window
    always begin
        phyCol <= 1'b0;
        @(negedge txEn);
        if (colOn) begin
            repeat (colDelay) @(posedge clk);
            phyCol <= 1'b1;
            repeat (3) @(posedge clk);
        end
    end
endmodule : phy_col_model

// ### verif/mac_rx_error_statistics_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module mac_rx_error_statistics_tb;
    import mac_stats_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic              clk;
    logic              sys_rst;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWr;
    logic              regRd;
    logic [DATA_W-1:0] regRdData;
    rx_frame_t         rxFrame;
    logic              txEn = 1'b0;
    logic              txUnderrun;
    logic              phyCol;
    logic              fcsErrInc;
    logic              alignErrInc;
    logic              irq;
    logic              colOn = 1'b0;
    logic [7:0]        colDelay;
    logic [31:0]       exp [NUM_CNT];
    int                mismatches;
    int                compares;
    int                cycles;

    mac_rx_error_statistics mac_rx_error_statistics_i (.clk(clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .rxFrame(rxFrame), .txEn(txEn), .txUnderrun(txUnderrun),
        .phyCol(phyCol), .fcsErrInc(fcsErrInc), .alignErrInc(alignErrInc), .irq(irq));
    phy_col_model phy_col_model_i (.clk(clk), .txEn(txEn), .colOn(colOn),
        .colDelay(colDelay), .phyCol(phyCol));

    // ----------------------------------------
    // Bus and frame tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask : rdChk

    // Every counter is read, so a stray increment anywhere shows up
    task automatic checkAll();
        for (int i = 0; i < NUM_CNT; i++) rdChk(8'(i * 4), exp[i]);
    endtask : checkAll

    function automatic void bump(input int i);
        exp[i] = (exp[i] + 1) & {16'h0000, (i == CNT_NO_BUF) ? CNT_MASK_WIDE : CNT_MASK_NARROW};
    endfunction : bump

    // Flags: addrMatch, noBuffer, dmaOverrun, crcErr, alignErr, symErr
    task automatic frame(input logic [15:0] l, lf, input logic [5:0] f, input logic fc, al);
        @(posedge clk);
        rxFrame <= {1'b1, l, lf, f};
        @(posedge clk);
        rxFrame.valid <= 1'b0;
        #1;
        // Pulses stand only in the cycle after the report edge
        `CHK({fcsErrInc, alignErrInc}, {fc, al})
        repeat (2) @(posedge clk);
        #1;
    endtask : frame

    task automatic tx(input logic on, input logic [7:0] dly, input logic und);
        colOn <= on;
        colDelay <= dly;
        @(posedge clk);
        txEn <= 1'b1;
        repeat (3) @(posedge clk);
        txUnderrun <= und;
        @(posedge clk);
        txUnderrun <= 1'b0;
        repeat (4) @(posedge clk);
        txEn <= 1'b0;
        // Long enough for the 10 Mb/s window to close
        repeat (200) @(posedge clk);
    endtask : tx

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        checkAll();
        rdChk(OFF_NET_CFG, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rdChk(8'h40, 32'h0000_0000);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_rx_counts();
        frame(100, 0, 6'b110000, 0, 0); bump(CNT_NO_BUF);
        frame(100, 0, 6'b101000, 0, 0); bump(CNT_OVERRUN);
        frame(100, 0, 6'b100001, 1, 0); bump(CNT_SYMBOL);
        frame(100, 0, 6'b100011, 0, 1); bump(CNT_SYMBOL);
        frame(1600, 0, 6'b100001, 0, 0); bump(CNT_SYMBOL); bump(CNT_OVER_BAD);
        frame(1600, 0, 6'b100000, 0, 0); bump(CNT_OVER_CLEAN);
        frame(1519, 0, 6'b100100, 0, 0); bump(CNT_OVER_BAD);
        frame(1518, 0, 6'b100100, 1, 0);
        frame(64, 0, 6'b100100, 1, 0);
        frame(63, 0, 6'b100000, 0, 0); bump(CNT_SHORT_CLEAN);
        frame(63, 0, 6'b100100, 0, 0);
        checkAll();
        $display("t_rx_counts done");
    endtask : t_rx_counts

    task automatic t_big_frames();
        wr(OFF_NET_CFG, 32'h0000_0100);
        frame(1536, 0, 6'b100100, 1, 0);
        frame(1537, 0, 6'b100000, 0, 0); bump(CNT_OVER_CLEAN);
        wr(OFF_NET_CFG, 32'h0000_0000);
        frame(1530, 0, 6'b100000, 0, 0); bump(CNT_OVER_CLEAN);
        checkAll();
        $display("t_big_frames done");
    endtask : t_big_frames

    task automatic t_length();
        frame(100, 200, 6'b100000, 0, 0);
        wr(OFF_NET_CFG, 32'h0001_0000);
        frame(100, 200, 6'b100000, 0, 0); bump(CNT_LEN_MISMATCH);
        frame(100, 82, 6'b100000, 0, 0);
        frame(100, 83, 6'b100000, 0, 0); bump(CNT_LEN_MISMATCH);
        frame(100, 16'h05FF, 6'b100000, 0, 0); bump(CNT_LEN_MISMATCH);
        frame(100, 16'h0600, 6'b100000, 0, 0);
        frame(1600, 1590, 6'b100000, 0, 0); bump(CNT_OVER_CLEAN);
        checkAll();
        $display("t_length done");
    endtask : t_length

    task automatic t_write();
        wr(8'h00, 32'h0001_2345); exp[CNT_NO_BUF] = 32'h0000_2345;
        wr(8'h14, 32'h0000_00FF); exp[CNT_SHORT_CLEAN] = 32'h0000_00FF;
        frame(40, 0, 6'b100000, 0, 0); bump(CNT_SHORT_CLEAN);
        checkAll();
        $display("t_write done");
    endtask : t_write

    task automatic t_heartbeat();
        tx(1, 150, 0);
        tx(0, 0, 0); bump(CNT_HEARTBEAT);
        wr(OFF_NET_CFG, 32'h0000_0001);
        tx(1, 4, 0);
        tx(1, 25, 0); bump(CNT_HEARTBEAT);
        tx(0, 0, 0); bump(CNT_HEARTBEAT);
        tx(0, 0, 1); bump(CNT_TX_UNDERRUN);
        wr(OFF_NET_CFG, 32'h0000_0003);
        tx(0, 0, 0);
        checkAll();
        $display("t_heartbeat done");
    endtask : t_heartbeat

    task automatic t_irq();
        wr(OFF_IRQ_STATUS, 32'h0000_01FF);
        rdChk(OFF_IRQ_STATUS, 32'h0000_0000);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        `CHK(irq, 1'b0)
        frame(100, 0, 6'b110000, 0, 0); bump(CNT_NO_BUF);
        `CHK(irq, 1'b1)
        rdChk(OFF_IRQ_STATUS, 32'h0000_0001);
        wr(OFF_IRQ_MASK, 32'h0000_0000);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_STATUS, 32'h0000_0001);
        `CHK(irq, 1'b0)
        checkAll();
        $display("t_irq done");
    endtask : t_irq

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Whole run needs well under 10000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        regAddr = '0;
        regWrData = '0;
        regWr = 1'b0;
        regRd = 1'b0;
        rxFrame = '0;
        txUnderrun = 1'b0;
        colDelay = 8'h00;
        foreach (exp[i]) exp[i] = 32'h0000_0000;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_rx_counts();
        t_big_frames();
        t_length();
        t_write();
        t_heartbeat();
        t_irq();
        stop_test();
    end
endmodule : mac_rx_error_statistics_tb
